// File: shared/wdg_consts.svh
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// Register map, byte address on the bus
`define WDG_REG_ADDR    32'h0000_00D8
`define WDG_RESET_VAL   8'hFE
`define WDG_ACT_BIT     0
`define WDG_TRIG_BIT    1
`define WDG_CNT_LSB     1
`define WDG_CNT_MSB     7
`define WDG_CNT_W       7
`define WDG_DATA_W      8
`define WDG_BUS_PAD     24'h00_0000

// Count step: 384 us at an 8 MHz reference oscillator
`define WDG_STEP_US     384
`define WDG_REF_MHZ     8
`define WDG_STEP_CYC    (`WDG_STEP_US * `WDG_REF_MHZ)
`define WDG_PRE_W       12

// Reset pulse on the pin, typically 500 ns
`define WDG_CLK_MHZ     20
`define WDG_RST_NS      500
`define WDG_RST_CYC     ((`WDG_RST_NS * `WDG_CLK_MHZ) / 1000)
`define WDG_RST_W       4

// AHB transfer type bit that marks an active transfer
`define WDG_HTRANS_ACT  1

`endif

// File: shared/wdg_pkg.sv
package wdg_pkg;

    // Option bits sampled once after reset
    typedef struct packed {
        logic hw_act;
        logic ext_ctl;
    } wdg_cfg_s;

    // Latched AHB address phase
    typedef struct packed {
        logic write;
        logic hit;
    } wdg_aphase_s;

    // Reset pulse sequencer
    typedef enum logic [1:0] {
        WDG_RST_IDLE,
        WDG_RST_PULSE,
        WDG_RST_HOLD
    } wdg_rst_state_e;

endpackage

// File: src/wdg_stop_ctl.sv
`timescale 1ns/1ps
`include "wdg_consts.svh"

module wdg_stop_ctl
    import wdg_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        opt_hw_activation,
    input  wire logic        opt_ext_stop_ctrl,
    input  wire logic        stop_permit_pin,
    input  wire logic        stop_instr,
    input  wire logic        wake_irq,
    output logic             enter_stop,
    output logic             enter_wait,
    output logic             stop_mode,
    output logic             rst_pin_o,
    output logic             rst_pin_oe
);

    // Bit order swap between register and logical count
    function automatic logic [`WDG_CNT_W-1:0] wdg_rev7(
        input logic [`WDG_CNT_W-1:0] v
    );
        logic [`WDG_CNT_W-1:0] r;
        r = '0;
        for (int i = 0; i < `WDG_CNT_W; i++) begin
            r[i] = v[`WDG_CNT_W-1-i];
        end
        return r;
    endfunction

    localparam logic [`WDG_PRE_W-1:0] STEP_LAST =
        `WDG_PRE_W'(`WDG_STEP_CYC - 1);
    localparam logic [`WDG_RST_W-1:0] RST_LAST =
        `WDG_RST_W'(`WDG_RST_CYC - 1);

    wdg_cfg_s              cfg_ff;
    logic                  cfg_vld_ff;
    logic                  permit_meta_ff;
    logic                  permit_ff;
    wdg_aphase_s           aph_ff;
    logic [`WDG_CNT_W-1:0] raw_ff;
    logic [`WDG_CNT_W-1:0] nxt_raw;
    logic                  act_ff;
    logic                  nxt_act;
    logic [`WDG_PRE_W-1:0] pre_ff;
    logic                  stop_ff;
    logic                  enter_stop_ff;
    logic                  enter_wait_ff;
    logic [31:0]           hrdata_ff;
    wdg_rst_state_e        rst_state_ff;
    logic [`WDG_RST_W-1:0] rst_cnt_ff;

    wire logic                  ap_take;
    wire logic                  ap_hit;
    wire logic                  wr_en;
    wire logic                  tick;
    wire logic [`WDG_CNT_W-1:0] cnt_now;
    wire logic [`WDG_CNT_W-1:0] cnt_dec;
    wire logic                  hw_forced;
    wire logic                  trig;
    wire logic                  stop_go;
    wire logic                  wait_go;
    wire logic [7:0]            rd_byte;

    // Bus decode
    assign ap_take = hsel & hready & htrans[`WDG_HTRANS_ACT];
    assign ap_hit  = (haddr == `WDG_REG_ADDR);
    assign wr_en   = aph_ff.write & aph_ff.hit;

    // Count arithmetic in logical bit order
    assign tick      = (pre_ff == STEP_LAST) & ~stop_ff;
    assign cnt_now   = wdg_rev7(raw_ff);
    assign cnt_dec   = cnt_now - `WDG_CNT_W'(1);
    assign hw_forced = cfg_vld_ff & cfg_ff.hw_act;

    // Next register value: a write wins over a decrement
    assign nxt_raw = wr_en ? hwdata[`WDG_CNT_MSB:`WDG_CNT_LSB]
                   : tick  ? wdg_rev7(cnt_dec)
                   : raw_ff;
    assign nxt_act = act_ff | hw_forced
                   | (wr_en & hwdata[`WDG_ACT_BIT]);

    // Reset trigger once active and the top count bit is clear
    assign trig = act_ff & ~raw_ff[`WDG_TRIG_BIT - `WDG_CNT_LSB];

    // STOP decision
    assign stop_go = stop_instr & ~stop_ff
                   & (~act_ff
                   | (cfg_ff.ext_ctl & permit_ff));
    assign wait_go = stop_instr & ~stop_ff & act_ff
                   & (~cfg_ff.ext_ctl
                   | ~permit_ff);

    // Read value reflects this cycle's write and decrement
    assign rd_byte = {nxt_raw, nxt_act};

    // Option capture after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff     <= '0;
            cfg_vld_ff <= 1'b0;
        end else if (!cfg_vld_ff) begin
            cfg_ff     <= '{opt_hw_activation, opt_ext_stop_ctrl};
            cfg_vld_ff <= 1'b1;
        end
    end

    // Permit pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            permit_meta_ff <= 1'b0;
            permit_ff      <= 1'b0;
        end else begin
            permit_meta_ff <= stop_permit_pin;
            permit_ff      <= permit_meta_ff;
        end
    end

    // AHB address phase latch and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_ff    <= '0;
            hrdata_ff <= '0;
        end else if (hready) begin
            aph_ff    <= '{hwrite, ap_take & ap_hit};
            hrdata_ff <= (ap_take & ap_hit & ~hwrite)
                       ? {`WDG_BUS_PAD, rd_byte} : '0;
        end
    end

    // Count and activation register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_ff <= `WDG_CNT_W'(`WDG_RESET_VAL >> `WDG_CNT_LSB);
            act_ff <= 1'b0;
        end else begin
            raw_ff <= nxt_raw;
            act_ff <= nxt_act;
        end
    end

    // Step prescaler, held while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_ff <= '0;
        end else if (tick) begin
            pre_ff <= '0;
        end else if (!stop_ff) begin
            pre_ff <= pre_ff + `WDG_PRE_W'(1);
        end
    end

    // Low power mode state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_ff       <= 1'b0;
            enter_stop_ff <= 1'b0;
            enter_wait_ff <= 1'b0;
        end else begin
            enter_stop_ff <= stop_go;
            enter_wait_ff <= wait_go;
            if (stop_go) begin
                stop_ff <= 1'b1;
            end else if (wake_irq) begin
                stop_ff <= 1'b0;
            end
        end
    end

    // Reset pulse sequencer, held until the chip reset arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_state_ff <= WDG_RST_IDLE;
            rst_cnt_ff   <= '0;
        end else begin
            case (rst_state_ff)
                WDG_RST_IDLE: begin
                    if (trig) begin
                        rst_state_ff <= WDG_RST_PULSE;
                    end
                end
                WDG_RST_PULSE: begin
                    rst_cnt_ff <= rst_cnt_ff + `WDG_RST_W'(1);
                    if (rst_cnt_ff == RST_LAST) begin
                        rst_state_ff <= WDG_RST_HOLD;
                    end
                end
                WDG_RST_HOLD: begin
                    rst_state_ff <= WDG_RST_HOLD;
                end
                default: begin
                    rst_state_ff <= WDG_RST_IDLE;
                end
            endcase
        end
    end

    // Outputs
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_ff;
    assign enter_stop = enter_stop_ff;
    assign enter_wait = enter_wait_ff;
    assign stop_mode  = stop_ff;
    assign rst_pin_o  = 1'b0; // Open drain, drives low only
    assign rst_pin_oe = (rst_state_ff == WDG_RST_PULSE);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Helper: length of each reset pulse
    logic [`WDG_RST_W:0] pulse_len_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_len_ff <= '0;
        end else if (rst_pin_oe) begin
            pulse_len_ff <= pulse_len_ff + (`WDG_RST_W+1)'(1);
        end
    end

    // Helper: cycles between two count steps
    logic [`WDG_PRE_W:0] gap_ff;
    logic                gap_vld_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff     <= '0;
            gap_vld_ff <= 1'b0;
        end else if (tick) begin
            gap_ff     <= '0;
            gap_vld_ff <= 1'b1;
        end else if (!stop_ff) begin
            gap_ff <= gap_ff + (`WDG_PRE_W+1)'(1);
        end
    end

    sequence s_stop_taken;
        stop_instr && !stop_ff && act_ff && cfg_ff.ext_ctl && permit_ff;
    endsequence

    sequence s_stop_held;
        stop_ff && !enter_wait ##1 stop_ff;
    endsequence

    hw_act_forced_a: assert property (
        cfg_vld_ff && cfg_ff.hw_act |=> act_ff && rd_byte[0])
        else $error("activation bit not forced by option");

    act_sticky_a: assert property (
        act_ff |=> act_ff)
        else $error("watchdog deactivated without reset");

    wait_runs_a: assert property (
        enter_wait |-> !stop_ff ##1 !stop_ff)
        else $error("WAIT froze the watchdog");

    stop_inactive_a: assert property (
        stop_instr && !stop_ff && !act_ff |=> enter_stop && stop_ff)
        else $error("inactive watchdog blocked STOP");

    stop_as_wait_a: assert property (
        stop_instr && !stop_ff && act_ff && !cfg_ff.ext_ctl
        |=> enter_wait && !enter_stop && !stop_ff)
        else $error("STOP not turned into WAIT");

    permit_low_a: assert property (
        stop_instr && !stop_ff && act_ff && cfg_ff.ext_ctl && !permit_ff
        |=> enter_wait && !stop_ff)
        else $error("STOP with permit low not WAIT");

    stop_freeze_a: assert property (
        s_stop_taken ##1 s_stop_held |-> !tick && $stable(pre_ff))
        else $error("counter moved during STOP");

    wake_resume_a: assert property (
        stop_ff && wake_irq && !stop_instr |=> !stop_ff ##1 pre_ff != $past(pre_ff))
        else $error("counter did not resume after wake");

    read_layout_a: assert property (
        ap_take && ap_hit && !hwrite && hready
        |=> hrdata[7:1] == raw_ff && hrdata[0] == act_ff && hrdata[31:8] == '0)
        else $error("register read layout wrong");

    timer_dec_a: assert property (
        tick && !wr_en |=> wdg_rev7(raw_ff) == $past(cnt_dec))
        else $error("counter did not step down by one");

    step_gap_a: assert property (
        tick && gap_vld_ff |-> gap_ff == (`WDG_PRE_W+1)'(`WDG_STEP_CYC - 1))
        else $error("count step period wrong");

    reset_start_a: assert property (
        trig && rst_state_ff == WDG_RST_IDLE |=> rst_pin_oe ##1 rst_pin_oe)
        else $error("reset pulse not started");

    reset_len_a: assert property (
        $fell(rst_pin_oe) |-> pulse_len_ff == (`WDG_RST_W+1)'(`WDG_RST_CYC))
        else $error("reset pulse length wrong");

    // One pulse only, then wait for the chip reset
    reset_hold_a: assert property (
        rst_state_ff == WDG_RST_HOLD |=> !rst_pin_oe && rst_state_ff == WDG_RST_HOLD)
        else $error("reset pin driven again after pulse");

    count_runs_a: assert property (
        !stop_ff |=> pre_ff != $past(pre_ff))
        else $error("prescaler halted outside STOP");

    stop_ignored_a: assert property (
        stop_ff && stop_instr |=> !enter_stop && !enter_wait)
        else $error("STOP instruction acted on while stopped");

    decide_excl_a: assert property (
        !(enter_stop && enter_wait))
        else $error("STOP and WAIT both chosen");

endmodule

// File: bench/wdg_stop_ctl_tb.sv
`timescale 1ns/1ps
`include "wdg_consts.svh"

module wdg_stop_ctl_tb
    import wdg_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        opt_hw;
    logic        opt_ext;
    logic        permit;
    logic        stop_i;
    logic        wake;
    logic        enter_stop;
    logic        enter_wait;
    logic        stop_mode;
    logic        rst_o;
    logic        rst_oe;
    int          num_errors;
    int          n_checks;
    int          n;
    int          cyc = 0;
    logic [31:0] d;
    logic [31:0] d2;
    logic [7:0]  v;
    // Rows: hw option, ext option, software sets C, permit, expected stop, expected wait
    logic [5:0]  rows [6] = '{6'b00_0_1_10, 6'b10_0_1_01, 6'b00_1_1_01, 6'b11_0_0_01, 6'b11_0_1_10, 6'b01_0_1_10};

    wdg_stop_ctl wdg_stop_ctl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .opt_hw_activation(opt_hw), .opt_ext_stop_ctrl(opt_ext), .stop_permit_pin(permit),
        .stop_instr(stop_i), .wake_irq(wake), .enter_stop(enter_stop), .enter_wait(enter_wait),
        .stop_mode(stop_mode), .rst_pin_o(rst_o), .rst_pin_oe(rst_oe)
    );

    // Clock at 20 MHz
    always #25 hclk = ~hclk;

    // Free cycle count for step timing
    always @(posedge hclk) cyc <= cyc + 1;

    // Count after one decrement of the bit-reversed 7-bit value
    function automatic logic [7:0] step(input logic [7:0] r);
        logic [6:0] l;
        logic [6:0] s;
        l = {<<{r[7:1]}};
        l = l - 7'h01;
        s = {<<{l}};
        return {s, r[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset with options applied; options stay static afterwards
    task automatic rst(input logic hw, input logic ext);
        @(posedge hclk);
        hresetn <= 1'b0;
        opt_hw  <= hw;
        opt_ext <= ext;
        permit  <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask

    // Single AHB-Lite word transfer
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {`WDG_BUS_PAD, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic stop_pulse;
        @(posedge hclk);
        stop_i <= 1'b1;
        @(posedge hclk);
        stop_i <= 1'b0;
        @(negedge hclk);
    endtask

    // Single reads, one every three cycles; n is the cycle count from the previous change (or first read) to the k-th change
    task automatic watch(input int k, output int n, output logic [7:0] v);
        logic [31:0] r;
        logic [7:0]  prev;
        int          c;
        int          t;
        int          t0;
        int          tc;
        bus(1'b0, `WDG_REG_ADDR, 8'h00, r);
        prev = r[7:0];
        v = prev;
        t0 = cyc;
        n = 0;
        c = 0;
        t = 0;
        while (c < k && t < 1400) begin
            bus(1'b0, `WDG_REG_ADDR, 8'h00, r);
            v = r[7:0];
            tc = cyc;
            t++;
            if (v !== prev) begin
                chk("count", step(prev), v);
                bus(1'b0, `WDG_REG_ADDR, 8'h00, r);
                chk("reread", v, r[7:0]);
                n = tc - t0;
                t0 = tc;
                prev = v;
                c++;
                t = 0;
            end
        end
        if (c < k) n = 32'h000F_FFFF;
    endtask

    // Watchdog against a hang
    initial begin
        #(50 * 60000);
        num_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
        hwdata = 0; opt_hw = 0; opt_ext = 0; permit = 0; stop_i = 0; wake = 0;
        num_errors = 0;
        n_checks = 0;
        foreach (rows[i]) begin
            rst(rows[i][5], rows[i][4]);
            if (rows[i][3]) bus(1'b1, `WDG_REG_ADDR, 8'hFF, d);
            permit <= rows[i][2];
            repeat (3) @(posedge hclk);
            stop_pulse();
            chk("enter_stop", rows[i][1], enter_stop);
            chk("enter_wait", rows[i][0], enter_wait);
            chk("stop_mode", rows[i][1], stop_mode);
        end
        // Reset value, unmapped address, sticky activation
        rst(1'b0, 1'b0);
        bus(1'b0, `WDG_REG_ADDR, 8'h00, d);
        chk("reset_value", 32'h0000_00FE, d);
        chk("hresp", 32'h0, hresp);
        chk("hreadyout", 32'h1, hreadyout);
        bus(1'b0, 32'h0000_00DC, 8'h00, d);
        chk("unmapped", 32'h0, d);
        bus(1'b1, `WDG_REG_ADDR, 8'hFF, d);
        bus(1'b1, `WDG_REG_ADDR, 8'hFE, d);
        bus(1'b0, `WDG_REG_ADDR, 8'h00, d);
        chk("sw_act", 32'h1, d[0]);
        rst(1'b1, 1'b0);
        bus(1'b1, `WDG_REG_ADDR, 8'hFE, d);
        bus(1'b0, `WDG_REG_ADDR, 8'h00, d);
        chk("hw_act", 32'h1, d[0]);
        // Step period as plain timer, then in WAIT with hardware activation
        for (int j = 0; j < 2; j++) begin
            rst(j[0], 1'b0);
            if (j == 1) stop_pulse();
            watch(2, n, v);
            chk("step_cycles", `WDG_STEP_CYC, n);
        end
        // Counter frozen in STOP, resumes after wake
        rst(1'b1, 1'b1);
        permit <= 1'b1;
        repeat (3) @(posedge hclk);
        stop_pulse();
        bus(1'b0, `WDG_REG_ADDR, 8'h00, d);
        repeat (3200) @(posedge hclk);
        bus(1'b0, `WDG_REG_ADDR, 8'h00, d2);
        chk("frozen", d, d2);
        @(posedge hclk);
        wake <= 1'b1;
        @(posedge hclk);
        wake <= 1'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("stop_exit", 32'h0, stop_mode);
        watch(1, n, v);
        chk("resume", 32'h1, n <= `WDG_STEP_CYC);
        // Reset pulse width after clearing the trigger bit
        rst(1'b1, 1'b0);
        bus(1'b1, `WDG_REG_ADDR, 8'hFD, d);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (rst_oe !== 1'b1 && n < 5);
        n = 0;
        while (rst_oe === 1'b1 && n < 20) begin
            @(negedge hclk);
            n++;
        end
        chk("rst_len", `WDG_RST_CYC, n);
        chk("rst_drive", 32'h0, rst_o);
        summarize();
    end
endmodule
